//--- inc/tswd_pkg.sv
// constants and types for the two-stage watchdog
// Function
// R1: boot enable loads 65535-tenth first countdown
// R2: boot switch off leaves watchdog disabled
// R3: first expiry warns host, starts final stage
// R4: final stage defaults to one second
// R5: final stage expiry resets the whole system
// R6: reset is done by toggling power
// R7: host restarts first stage before expiry
// R8: host restarts watchdog after a watchdog reset
// R9: output-full and vendor flags stay set
// R10: host clears output-full by reading one byte
// R11: final stage waits for dispatched warning
// R12: clear-interrupt rewinds and cancels pending action
// R13: get, set and heartbeat commands supported
// R14: zero final reload resets at first expiry
// R15: set with all-ones values stops watchdog
// R16: running final stage cannot be stopped
// R17: starting a stage restarts the running one
// R18: first value kept no greater than final; code lowers first only on a set made in the first stage and raises final on a set made in the final stage
// R19: tenth-second prescaler drives first-stage countdown
// R20: second tick drives final stage after interlock
package tswd_pkg;
  localparam int unsigned TSWD_CLK_HZ = 125000000;
  localparam int unsigned TSWD_TICK_MS = 100;
  localparam int unsigned TSWD_TICK_CYCLES = TSWD_CLK_HZ / 1000 * TSWD_TICK_MS;
  localparam int unsigned TSWD_POWER_OFF_MS = 100;
  localparam int unsigned TSWD_POWER_OFF_CYCLES = TSWD_CLK_HZ / 1000 * TSWD_POWER_OFF_MS;
  localparam int unsigned TSWD_DIV_W = 27;
  localparam int unsigned TSWD_FIRST_W = 16;
  localparam int unsigned TSWD_FINAL_W = 8;
  localparam logic [3:0] TSWD_TICKS_PER_SEC = 4'ha;
  localparam logic [3:0] TSWD_TICKS_LAST = 4'h9;
  localparam logic [15:0] TSWD_FIRST_BOOT = 16'hffff;
  localparam logic [15:0] TSWD_FIRST_STOP = 16'hffff;
  localparam logic [7:0] TSWD_FINAL_DEFAULT = 8'h01;
  localparam logic [7:0] TSWD_FINAL_STOP = 8'hff;
  // register byte offsets
  localparam logic [7:0] TSWD_OFS_RELOAD = 8'h00;
  localparam logic [7:0] TSWD_OFS_HEARTBEAT = 8'h04;
  localparam logic [7:0] TSWD_OFS_STATUS = 8'h08;
  localparam logic [7:0] TSWD_OFS_COUNT = 8'h0c;
  localparam logic [7:0] TSWD_OFS_HOSTPORT = 8'h10;
  localparam logic [7:0] TSWD_OFS_CLEARINT = 8'h14;
  // field positions
  localparam int unsigned TSWD_FINAL_LSB = 16;
  localparam int unsigned TSWD_ST_ENABLED = 0;
  localparam int unsigned TSWD_ST_FIRST = 1;
  localparam int unsigned TSWD_ST_WARN = 2;
  localparam int unsigned TSWD_ST_FINAL = 3;
  localparam int unsigned TSWD_ST_POWER = 4;
  localparam int unsigned TSWD_ST_EXPIRED = 5;
  localparam int unsigned TSWD_HP_FULL = 0;
  localparam int unsigned TSWD_HP_VENDOR = 1;
  typedef enum logic [2:0] {
    TSWD_IDLE = 3'b000,
    TSWD_FIRST = 3'b001,
    TSWD_WARN = 3'b010,
    TSWD_FINAL = 3'b011,
    TSWD_POWER = 3'b100
  } tswd_state_type;
endpackage : tswd_pkg

//--- core/tswd_top.sv
// two-stage watchdog core with apb register access
`timescale 1ns/1ns
module tswd_top
  import tswd_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = TSWD_TICK_CYCLES,
  parameter int unsigned POWER_OFF_CYCLES = TSWD_POWER_OFF_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic wd_boot_enable,
  output logic warn_req,
  input wire logic warn_ack,
  output logic power_off,
  input wire logic host_byte_read,
  output logic host_output_full_flag,
  output logic vendor_status_flag
);

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == TSWD_OFS_RELOAD) || (a == TSWD_OFS_HEARTBEAT) ||
             (a == TSWD_OFS_STATUS) || (a == TSWD_OFS_COUNT) ||
             (a == TSWD_OFS_HOSTPORT) || (a == TSWD_OFS_CLEARINT);
  endfunction : mapped

  // first-stage value expressed in whole seconds, rounded up, saturated
  // one spare bit keeps the round-up from wrapping near full scale
  function automatic logic [7:0] to_secs(input logic [15:0] tenths);
    logic [16:0] s;
    s = (17'(tenths) + 17'(TSWD_TICKS_LAST)) / 17'(TSWD_TICKS_PER_SEC);
    to_secs = (s > 17'(TSWD_FINAL_STOP)) ? TSWD_FINAL_STOP : s[7:0];
  endfunction : to_secs

  tswd_state_type state_q, state_d;
  logic [15:0] first_rl_q, first_rl_d;
  logic [7:0] final_rl_q, final_rl_d;
  logic [15:0] first_cnt_q, first_cnt_d;
  logic [7:0] final_cnt_q, final_cnt_d;
  logic [TSWD_DIV_W-1:0] div_q, div_d;
  logic [3:0] sec_div_q, sec_div_d;
  logic [TSWD_DIV_W-1:0] pwr_q, pwr_d;
  logic boot_done_q, boot_done_d;
  logic expired_q, expired_d;
  logic full_q, full_d;
  logic vendor_q, vendor_d;
  logic [31:0] rdata_q, rdata_d;
  logic rd_loaded_q, rd_loaded_d;

  logic acc, wr;
  logic wr_reload, wr_hb, wr_status, wr_clear;
  logic tenth_tick, sec_tick;
  logic [15:0] new_first;
  logic [7:0] new_final;
  logic stop_req;

  assign pready = ce & rd_loaded_q;
  assign acc = psel & penable & pready;
  assign wr = acc & pwrite & mapped(paddr);
  assign pslverr = acc & ~mapped(paddr);
  assign prdata = rdata_q;
  assign wr_reload = wr && (paddr == TSWD_OFS_RELOAD);
  assign wr_hb = wr && (paddr == TSWD_OFS_HEARTBEAT);
  assign wr_status = wr && (paddr == TSWD_OFS_STATUS);
  assign wr_clear = wr && (paddr == TSWD_OFS_CLEARINT);
  assign new_first = pwdata[TSWD_FINAL_LSB-1:0];
  assign new_final = pwdata[TSWD_FINAL_LSB +: TSWD_FINAL_W];
  assign stop_req = (new_first == TSWD_FIRST_STOP) && (new_final == TSWD_FINAL_STOP);
  assign warn_req = (state_q == TSWD_WARN);
  assign power_off = (state_q == TSWD_POWER);
  assign host_output_full_flag = full_q;
  assign vendor_status_flag = vendor_q;

  // prescaler: free-running tenth-second tick
  always_comb begin
    div_d = div_q + 1'b1;
    tenth_tick = 1'b0;
    if (div_q == TSWD_DIV_W'(TICK_CYCLES - 1)) begin // [R19]
      div_d = '0;
      tenth_tick = 1'b1;
    end
  end

  // read data is captured in the setup cycle, so the access cycle answers at once
  always_comb begin
    rd_loaded_d = psel & ~(penable & pready);
    rdata_d = rdata_q;
    if (psel && !penable) begin
      unique case (paddr)
        TSWD_OFS_RELOAD: rdata_d = {8'h00, final_rl_q, first_rl_q}; // [R13]
        TSWD_OFS_STATUS: begin // [R13]
          rdata_d = '0;
          rdata_d[TSWD_ST_ENABLED] = (state_q != TSWD_IDLE);
          rdata_d[TSWD_ST_FIRST] = (state_q == TSWD_FIRST);
          rdata_d[TSWD_ST_WARN] = (state_q == TSWD_WARN);
          rdata_d[TSWD_ST_FINAL] = (state_q == TSWD_FINAL);
          rdata_d[TSWD_ST_POWER] = (state_q == TSWD_POWER);
          rdata_d[TSWD_ST_EXPIRED] = expired_q;
        end
        TSWD_OFS_COUNT: rdata_d = {8'h00, final_cnt_q, first_cnt_q}; // [R13]
        TSWD_OFS_HOSTPORT: rdata_d = {30'h0, vendor_q, full_q};
        default: rdata_d = '0;
      endcase
    end
  end

  // reload registers written by the set command
  always_comb begin
    first_rl_d = first_rl_q;
    final_rl_d = final_rl_q;
    if (!boot_done_q && wd_boot_enable) begin
      first_rl_d = TSWD_FIRST_BOOT; // [R1]
    end else if (wr_reload) begin // [R13]
      first_rl_d = new_first;
      final_rl_d = new_final;
      if (stop_req) begin
        first_rl_d = new_first;
      end else if (state_q == TSWD_FIRST &&
                   16'(new_final) * 16'(TSWD_TICKS_PER_SEC) < new_first) begin
        first_rl_d = 16'(new_final) * 16'(TSWD_TICKS_PER_SEC); // [R18]
      end else if (state_q == TSWD_FINAL && to_secs(new_first) > new_final) begin
        final_rl_d = to_secs(new_first); // [R18]
      end
    end
  end

  // main sequencer
  always_comb begin
    state_d = state_q;
    first_cnt_d = first_cnt_q;
    final_cnt_d = final_cnt_q;
    sec_div_d = sec_div_q;
    pwr_d = pwr_q;
    boot_done_d = 1'b1;
    expired_d = expired_q;
    sec_tick = 1'b0;
    if (state_q == TSWD_FINAL && tenth_tick) begin
      sec_div_d = sec_div_q + 1'b1;
      if (sec_div_q == TSWD_TICKS_LAST) begin // [R20]
        sec_div_d = '0;
        sec_tick = 1'b1;
      end
    end
    if (wr_status && pwdata[TSWD_ST_EXPIRED]) begin
      expired_d = 1'b0;
    end
    unique case (state_q)
      TSWD_IDLE: begin
        if (!boot_done_q && wd_boot_enable) begin
          state_d = TSWD_FIRST; // [R1]
          first_cnt_d = TSWD_FIRST_BOOT;
        end else if (wr_hb && !(first_rl_q == TSWD_FIRST_STOP &&
                                final_rl_q == TSWD_FINAL_STOP)) begin
          state_d = TSWD_FIRST; // [R2] [R8] [R13]
          first_cnt_d = first_rl_q;
        end
      end
      TSWD_FIRST: begin
        if (wr_reload && stop_req) begin
          state_d = TSWD_IDLE; // [R15]
        end else if (wr_hb || wr_clear) begin
          first_cnt_d = first_rl_q; // [R7] [R17]
        end else if (tenth_tick) begin
          if (first_cnt_q <= 16'h0001) begin // [R19]
            first_cnt_d = '0;
            expired_d = 1'b1;
            state_d = (final_rl_q == '0) ? TSWD_POWER : TSWD_WARN; // [R14] [R3]
          end else begin
            first_cnt_d = first_cnt_q - 1'b1; // [R19]
          end
        end
      end
      TSWD_WARN: begin
        if (wr_reload && stop_req) begin
          state_d = TSWD_IDLE; // [R15]
        end else if (wr_hb || wr_clear) begin
          state_d = TSWD_FIRST; // [R12]
          first_cnt_d = first_rl_q;
        end else if (warn_ack) begin
          state_d = TSWD_FINAL; // [R11] [R3]
          final_cnt_d = final_rl_q;
          sec_div_d = '0;
        end
      end
      TSWD_FINAL: begin
        // stop requests are ignored here on purpose
        if (wr_clear) begin
          state_d = TSWD_FIRST; // [R12]
          first_cnt_d = first_rl_q;
        end else if (wr_hb) begin
          final_cnt_d = final_rl_q; // [R17] [R16]
          sec_div_d = '0;
        end else if (sec_tick) begin
          if (final_cnt_q <= 8'h01) begin
            final_cnt_d = '0;
            state_d = TSWD_POWER; // [R5]
          end else begin
            final_cnt_d = final_cnt_q - 1'b1; // [R20] [R4]
          end
        end
      end
      TSWD_POWER: begin
        pwr_d = pwr_q + 1'b1;
        if (pwr_q == TSWD_DIV_W'(POWER_OFF_CYCLES - 1)) begin // [R6]
          pwr_d = '0;
          state_d = TSWD_IDLE; // [R8]
        end
      end
      default: state_d = TSWD_IDLE;
    endcase
  end

  // host port flags: only the host's byte read clears them
  always_comb begin
    full_d = full_q;
    vendor_d = vendor_q;
    if (host_byte_read) begin
      full_d = 1'b0; // [R10]
      vendor_d = 1'b0;
    end
    if (state_q == TSWD_WARN && warn_ack) begin
      full_d = 1'b1; // [R9]
    end
    if (state_q == TSWD_POWER) begin
      vendor_d = 1'b1; // [R9]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= TSWD_IDLE; // [R2]
      first_rl_q <= TSWD_FIRST_BOOT;
      final_rl_q <= TSWD_FINAL_DEFAULT; // [R4]
      first_cnt_q <= '0;
      final_cnt_q <= '0;
      div_q <= '0;
      sec_div_q <= '0;
      pwr_q <= '0;
      boot_done_q <= 1'b0;
      expired_q <= 1'b0;
      full_q <= 1'b0;
      vendor_q <= 1'b0;
      rdata_q <= '0;
      rd_loaded_q <= 1'b0;
    end else if (ce) begin
      state_q <= state_d;
      first_rl_q <= first_rl_d;
      final_rl_q <= final_rl_d;
      first_cnt_q <= first_cnt_d;
      final_cnt_q <= final_cnt_d;
      div_q <= div_d;
      sec_div_q <= sec_div_d;
      pwr_q <= pwr_d;
      boot_done_q <= boot_done_d;
      expired_q <= expired_d;
      full_q <= full_d;
      vendor_q <= vendor_d;
      rdata_q <= rdata_d;
      rd_loaded_q <= rd_loaded_d;
    end
  end

endmodule : tswd_top

//--- testbench/tswd_chk.sv
// port assertions for the two-stage watchdog
`timescale 1ns/1ns
module tswd_chk
  import tswd_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = TSWD_TICK_CYCLES,
  parameter int unsigned POWER_OFF_CYCLES = TSWD_POWER_OFF_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic warn_req,
  input wire logic warn_ack,
  input wire logic power_off,
  input wire logic host_byte_read,
  input wire logic host_output_full_flag
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // length of the current power-off pulse
  logic [31:0] pw_q;
  logic [31:0] pw_d;
  always_comb pw_d = power_off ? pw_q + 32'h1 : 32'h0;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) pw_q <= 32'h0;
    else pw_q <= pw_d;
  end
  ack_ends_warn_a: assert property (warn_req && warn_ack && ce |=> !warn_req)
    else $error("warning held after dispatch");
  ack_sets_full_a: assert property (warn_req && warn_ack && ce |=> host_output_full_flag)
    else $error("output full not set on dispatch");
  full_holds_a: assert property (host_output_full_flag && !host_byte_read |=> host_output_full_flag)
    else $error("output full cleared by device");
  read_clears_a: assert property (host_byte_read && ce && !warn_req && !power_off |=>
    !host_output_full_flag)
    else $error("byte read left output full");
  power_max_a: assert property (pw_q <= POWER_OFF_CYCLES)
    else $error("power off too long");
  power_len_a: assert property ($fell(power_off) |-> pw_q == POWER_OFF_CYCLES)
    else $error("power off too short");
  power_no_warn_a: assert property (power_off |-> !warn_req && !$past(warn_req))
    else $error("power off with undispatched warning");
  ready_next_a: assert property (psel && !penable && ce ##1 ce |-> pready)
    else $error("no ready in access");
  slverr_access_a: assert property (pslverr |-> psel && penable)
    else $error("error outside access");
  cover property ($rose(warn_req));
  cover property ($rose(power_off));
  cover property (pslverr);
  cover property (host_byte_read && host_output_full_flag);
endmodule : tswd_chk

//--- testbench/tswd_host_model.sv
// host side: dispatches warnings and drains the port byte
`timescale 1ns/1ns
module tswd_host_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic warn_req,
  input wire logic power_off,
  input wire logic [7:0] ack_delay,
  input wire logic read_req,
  output logic warn_ack,
  output logic host_byte_read
);
  logic [7:0] wait_q;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_q <= 8'h00;
      warn_ack <= 1'b0;
      host_byte_read <= 1'b0;
    end else begin
      // dispatch after a chosen host latency
      warn_ack <= warn_req && !warn_ack && wait_q == ack_delay;
      wait_q <= (warn_req && !warn_ack) ? wait_q + 8'h01 : 8'h00;
      // a rebooted host drains one byte and ignores stale status
      host_byte_read <= read_req && !power_off;
    end
  end
endmodule : tswd_host_model

//--- testbench/tb_top.sv
// self-checking bench for the two-stage watchdog
`timescale 1ns/1ns
module tb_top;
  import tswd_pkg::*;
  localparam int unsigned TICK = 10;
  localparam int unsigned PWR = 4;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic ce = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic wd_boot_enable = 1'b1;
  logic [7:0] ack_delay = 8'h14;
  logic read_req = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, warn_req, warn_ack, power_off, host_byte_read;
  logic host_output_full_flag, vendor_status_flag, err_q;
  logic [31:0] rd_q;
  logic [7:0] fin;
  int num_errors = 0;
  int num_checks = 0;
  int cyc = 0;
  int warns = 0;
  int t0;
  int seed = 32'hb12b;
  always #4 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (warn_req === 1'b1) warns <= warns + 1;
  end
  tswd_top #(.TICK_CYCLES(TICK), .POWER_OFF_CYCLES(PWR)) dut (.pclk, .presetn, .ce, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .wd_boot_enable, .warn_req,
    .warn_ack, .power_off, .host_byte_read, .host_output_full_flag, .vendor_status_flag);
  tswd_host_model host (.pclk, .presetn, .warn_req, .power_off, .ack_delay, .read_req,
    .warn_ack, .host_byte_read);
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // one apb transfer; data taken at the edge that sees pready
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd_q = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic wait_for(input logic pw, input logic lvl);
    do @(negedge pclk); while ((pw ? power_off : warn_req) !== lvl);
    @(posedge pclk);
  endtask : wait_for
  task automatic rst(input logic boot);
    presetn <= 1'b0;
    wd_boot_enable <= boot;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
  endtask : rst
  task automatic close_out();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : close_out
  initial begin
    repeat (20000) @(posedge pclk);
    num_errors++;
    close_out();
  end
  initial begin
    rst(1'b1);
    apb(1'b0, TSWD_OFS_RELOAD, 32'h0);
    chk("reload_rst", rd_q, 32'h0001ffff);
    apb(1'b0, TSWD_OFS_STATUS, 32'h0);
    chk("boot_run", rd_q[1:0], 2'b11);
    apb(1'b0, 8'h18, 32'h0);
    chk("unmapped_err", err_q, 1'b1);
    chk("unmapped_data", rd_q, 32'h0);
    apb(1'b1, TSWD_OFS_RELOAD, 32'h00ffffff);
    apb(1'b1, TSWD_OFS_HEARTBEAT, 32'h0);
    apb(1'b0, TSWD_OFS_STATUS, 32'h0);
    chk("stop_idle", rd_q[1:0], 2'b00);
    rst(1'b0);
    apb(1'b0, TSWD_OFS_STATUS, 32'h0);
    chk("boot_off", rd_q[0], 1'b0);
    apb(1'b1, TSWD_OFS_HEARTBEAT, 32'h0);
    apb(1'b0, TSWD_OFS_STATUS, 32'h0);
    chk("sw_start", rd_q[1], 1'b1);
    fin = 8'($unsigned($random(seed)) % 5 + 1);
    apb(1'b1, TSWD_OFS_RELOAD, {8'h00, fin, 16'd200});
    apb(1'b0, TSWD_OFS_RELOAD, 32'h0);
    chk("clamp_first", {16'h0, rd_q[15:0]}, fin * 32'd10);
    chk("clamp_final", rd_q[23:16], fin);
    apb(1'b1, TSWD_OFS_RELOAD, 32'h00ffffff);
    apb(1'b1, TSWD_OFS_RELOAD, 32'h00000003);
    t0 = warns;
    apb(1'b1, TSWD_OFS_HEARTBEAT, 32'h0);
    wait_for(1'b1, 1'b1);
    chk("direct_no_warn", warns, t0);
    wait_for(1'b1, 1'b0);
    chk("vendor_set", vendor_status_flag, 1'b1);
    read_req <= 1'b1;
    @(posedge pclk);
    read_req <= 1'b0;
    repeat (2) @(posedge pclk);
    @(negedge pclk);
    chk("vendor_clr", vendor_status_flag, 1'b0);
    @(posedge pclk);
    apb(1'b1, TSWD_OFS_RELOAD, {16'h0001, 16'($unsigned($random(seed)) % 4 + 2)});
    apb(1'b1, TSWD_OFS_HEARTBEAT, 32'h0);
    t0 = warns;
    // kicks every third cycle outrun even the longest first stage here
    repeat (20) apb(1'b1, TSWD_OFS_HEARTBEAT, 32'h0);
    chk("kick_holds", warns, t0);
    wait_for(1'b0, 1'b1);
    apb(1'b0, TSWD_OFS_STATUS, 32'h0);
    chk("warn_wait", rd_q[3:2], 2'b01);
    wait_for(1'b0, 1'b0);
    chk("full_set", host_output_full_flag, 1'b1);
    apb(1'b1, TSWD_OFS_CLEARINT, 32'h0);
    apb(1'b0, TSWD_OFS_STATUS, 32'h0);
    chk("clear_int", rd_q[3:1], 3'b001);
    t0 = warns;
    ce <= 1'b0;
    repeat (60) @(posedge pclk);
    chk("ce_freeze", warns, t0);
    ce <= 1'b1;
    apb(1'b0, TSWD_OFS_STATUS, 32'h0);
    chk("ce_state", rd_q[3:1], 3'b001);
    ack_delay <= 8'($unsigned($random(seed)) % 8);
    wait_for(1'b0, 1'b1);
    wait_for(1'b0, 1'b0);
    t0 = cyc;
    // raising the first stage while the final one runs must pull the final reload up
    apb(1'b1, TSWD_OFS_RELOAD, {8'h00, 8'h01, 16'hfffa});
    apb(1'b0, TSWD_OFS_RELOAD, 32'h0);
    chk("raise_final", rd_q[23:16], 8'hff);
    wait_for(1'b1, 1'b1);
    chk("final_time", (cyc - t0 >= 9 * TICK) && (cyc - t0 <= 11 * TICK), 1'b1);
    close_out();
  end
endmodule : tb_top
bind tswd_top tswd_chk #(.TICK_CYCLES(TICK_CYCLES), .POWER_OFF_CYCLES(POWER_OFF_CYCLES)) u_chk (
  .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pready(pready),
  .pslverr(pslverr), .warn_req(warn_req), .warn_ack(warn_ack), .power_off(power_off),
  .host_byte_read(host_byte_read), .host_output_full_flag(host_output_full_flag));
